// [pll_cal_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pll_cal_defs.svh"
// How it works
// RULE1: Divide reference by 2, 4, 8 or 16 for calibration clock; 16 after reset.
// RULE2: Software picks divider by detector rate: 8 below 50 MHz, 4 below 25 MHz.
// RULE3: Division by 16 accepts any rate but calibrates slowest.
// RULE4: Calibration starts only on a committed 0-to-1 of calibrate-now.
// RULE5: Software confirms reference, writes 0 and commits, then 1 and commits.
// RULE6: Software commits via update bit 0 at commit register after each write.
// RULE7: Clearing committed calibrate-now discards the calibration result.
// RULE8: Software keeps holdover enables at 00 during calibration.
// RULE9: Alignment field: 01 async reset, 10 sync reset, 00/11 nothing.
// RULE10: Three-bit reference and feedback path delay codes, reset to zero.
// RULE11: Divider code 00 divides by 2.
// RULE12: Detector rate is reference frequency over R count.
// RULE13: Codes 00 and 11 leave the counters running.
// RULE14: Writes land in shadow registers and reach active copy on commit.
module pll_cal_ctrl (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Avalon-MM slave
  input wire logic [9:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // Reference tick and alignment pin
  input wire logic refTick,
  input wire logic alignPin,
  // Counter and path controls
  output logic cntAsyncReset,
  output logic cntSyncReset,
  output logic [2:0] refPathDelay,
  output logic [2:0] fbPathDelay,
  // Calibration status
  output logic calClock,
  output logic calBusy,
  output logic calValid
);
  import pll_cal_pkg::*;
  cnt_cfg_s cntShadow_reg, cntShadow_next, cntActive_reg, cntActive_next;
  cal_cfg_s calShadow_reg, calShadow_next, calActive_reg, calActive_next;
  logic ack_reg, ack_next;
  logic [31:0] rdData_next;
  logic [7:0] idx;
  logic commit;
  logic calTick;
  logic cntAsync_next, cntSync_next;

  assign idx = avsAddress[9:2];
  assign commit = avsWrite && ack_reg && avsByteEnable[0]
    && idx == `COMMIT_IDX && avsWriteData[`COMMIT_BIT];

  // Bus handshake, shadow writes, commit and readback
  always_comb begin
    ack_next = (avsRead || avsWrite) && !ack_reg;
    cntShadow_next = cntShadow_reg;
    calShadow_next = calShadow_reg;
    cntActive_next = cntActive_reg;
    calActive_next = calActive_reg;
    rdData_next = 32'h0000_0000;
    if (avsWrite && ack_reg && avsByteEnable[0]) begin
      if (idx == `CNT_RST_DLY_IDX) begin
        cntShadow_next = avsWriteData[7:0]; // RULE14
      end
      if (idx == `CAL_CTRL_IDX) begin
        calShadow_next = avsWriteData[7:0]; // RULE14
      end
    end
    if (commit) begin
      cntActive_next = cntShadow_reg; // RULE14
      calActive_next = calShadow_reg; // RULE14
    end
    if (avsRead && !ack_reg) begin
      unique case (idx)
        `CNT_RST_DLY_IDX: rdData_next = {24'h00_0000, cntShadow_reg};
        `CAL_CTRL_IDX: rdData_next = {22'h00_0000, calValid, calBusy, calShadow_reg};
        default: rdData_next = 32'h0000_0000;
      endcase
    end
  end

  // Alignment pin effect on R, A and B counters
  always_comb begin
    cntAsync_next = 1'b0;
    cntSync_next = 1'b0;
    if (alignPin) begin
      cntAsync_next = (cntActive_reg.alignMode == `ALIGN_ASYNC); // RULE9
      cntSync_next = (cntActive_reg.alignMode == `ALIGN_SYNC); // RULE9 RULE13
    end
  end

  // Register state
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
      avsReadData <= 32'h0000_0000;
      avsWaitRequest <= 1'b1;
      cntShadow_reg <= `CNT_RST_DLY_RST; // RULE10
      cntActive_reg <= `CNT_RST_DLY_RST;
      calShadow_reg <= `CAL_CTRL_RST; // RULE1
      calActive_reg <= `CAL_CTRL_RST;
      cntAsyncReset <= 1'b0;
      cntSyncReset <= 1'b0;
      refPathDelay <= 3'h0;
      fbPathDelay <= 3'h0;
      calClock <= 1'b0;
    end else if (clkEn) begin
      ack_reg <= ack_next;
      avsWaitRequest <= !ack_next;
      if (avsRead && !ack_reg) begin
        avsReadData <= rdData_next;
      end
      cntShadow_reg <= cntShadow_next;
      cntActive_reg <= cntActive_next;
      calShadow_reg <= calShadow_next;
      calActive_reg <= calActive_next;
      cntAsyncReset <= cntAsync_next;
      cntSyncReset <= cntSync_next;
      refPathDelay <= cntActive_reg.refDelay; // RULE10
      fbPathDelay <= cntActive_reg.fbDelay; // RULE10
      calClock <= calTick;
    end
  end

  // Calibration clock from reference over R: 2, 4, 8 or 16
  cal_clk_divider calDivider (
    .mclk(mclk),
    .sysRst(sys_rst),
    .clkEn(clkEn),
    .refTick(refTick),
    .divSel(calActive_reg.calDiv), // RULE1 RULE3 RULE11 RULE12
    .calTick(calTick)
  );

  // Calibration run on committed edge only
  cal_sequencer calSeq (
    .mclk(mclk),
    .sysRst(sys_rst),
    .clkEn(clkEn),
    .calNowActive(calActive_reg.calNow), // RULE4 RULE7
    .calTick(calTick),
    .calBusy(calBusy),
    .calValid(calValid)
  );

  // Checks
  shadow_only_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE14
    clkEn && !commit |=> $stable(calActive_reg) && $stable(cntActive_reg))
    else $error("active copy changed without commit");
  align_async_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE9
    clkEn && alignPin && cntActive_reg.alignMode == `ALIGN_ASYNC |=> cntAsyncReset)
    else $error("async alignment reset missing");
  align_none_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE13
    clkEn && (cntActive_reg.alignMode == `ALIGN_NONE
    || cntActive_reg.alignMode == `ALIGN_NONE_ALT)
    |=> !cntAsyncReset && !cntSyncReset)
    else $error("counters reset in no-action mode");
  bus_answer_a: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("bus answer late");

  // Alignment outputs follow only their own mode
  align_sync_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE9
    clkEn && alignPin && cntActive_reg.alignMode == `ALIGN_SYNC
    |=> cntSyncReset)
    else $error("sync alignment reset missing");
  async_only_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE9
    clkEn && cntActive_reg.alignMode == `ALIGN_SYNC
    |=> !cntAsyncReset)
    else $error("async reset in sync mode");
  sync_only_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE9
    clkEn && cntActive_reg.alignMode == `ALIGN_ASYNC
    |=> !cntSyncReset)
    else $error("sync reset in async mode");
  align_idle_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE9
    clkEn && !alignPin
    |=> !cntAsyncReset && !cntSyncReset)
    else $error("counter reset without alignment pin");

  // Path delay outputs track the active copy
  ref_delay_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE10
    clkEn
    |=> refPathDelay == $past(cntActive_reg.refDelay))
    else $error("reference path delay not the active value");
  fb_delay_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE10
    clkEn
    |=> fbPathDelay == $past(cntActive_reg.fbDelay))
    else $error("feedback path delay not the active value");

  // Divided calibration clock never pulses twice in a row
  cal_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE1
    clkEn && calClock
    |=> !calClock)
    else $error("calibration clock pulse too long");

  // Bus handshake timing and read data holding
  wait_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && !avsRead && !avsWrite
    |=> avsWaitRequest)
    else $error("waitrequest low without request");
  wait_single_a: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && !avsWaitRequest
    |=> avsWaitRequest)
    else $error("waitrequest low for more than one cycle");
  read_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && !avsRead
    |=> $stable(avsReadData))
    else $error("read data changed without read");

  // Readback shows shadow values, unmapped places read zero
  read_cnt_a: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && avsRead && avsWaitRequest && idx == `CNT_RST_DLY_IDX
    |=> avsReadData == {24'h00_0000, $past(cntShadow_reg)})
    else $error("counter register readback wrong");
  read_cal_a: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && avsRead && avsWaitRequest && idx == `CAL_CTRL_IDX
    |=> avsReadData == {22'h00_0000, $past(calValid), $past(calBusy), $past(calShadow_reg)})
    else $error("calibration register readback wrong");
  read_unmapped_a: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && avsRead && avsWaitRequest
    && idx != `CNT_RST_DLY_IDX && idx != `CAL_CTRL_IDX
    |=> avsReadData == 32'h0000_0000)
    else $error("unmapped readback not zero");

  // Writes land in the shadow copy, commit copies it to the active one
  cal_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE14
    clkEn && avsWrite && !avsWaitRequest && avsByteEnable[0] && idx == `CAL_CTRL_IDX
    |=> calShadow_reg == $past(avsWriteData[7:0]))
    else $error("calibration shadow write lost");
  cnt_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE14
    clkEn && avsWrite && !avsWaitRequest && avsByteEnable[0] && idx == `CNT_RST_DLY_IDX
    |=> cntShadow_reg == $past(avsWriteData[7:0]))
    else $error("counter shadow write lost");
  lane_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && avsWrite && !avsByteEnable[0]
    |=> $stable(calShadow_reg) && $stable(cntShadow_reg))
    else $error("shadow written with lane off");
  commit_copy_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE14
    clkEn && commit
    |=> calActive_reg == $past(calShadow_reg) && cntActive_reg == $past(cntShadow_reg))
    else $error("commit did not copy shadows");

  // A committed rising edge of calibrate-now starts a run
  cal_start_a: assert property (@(posedge mclk) disable iff (sys_rst) // RULE4
    clkEn && $rose(calActive_reg.calNow)
    |=> calBusy)
    else $error("calibration did not start on edge");
endmodule
`default_nettype wire

// [pll_cal_defs.svh]
`ifndef PLL_CAL_DEFS_SVH
`define PLL_CAL_DEFS_SVH
// Register word offsets (byte address = 4 * index)
`define CNT_RST_DLY_IDX 8'h19
`define CAL_CTRL_IDX 8'h18
`define COMMIT_IDX 8'h32
// Reset values
`define CNT_RST_DLY_RST 8'h00
`define CAL_CTRL_RST 8'h06
// Field positions
`define CAL_NOW_BIT 0
`define CAL_DIV_LSB 1
`define ALIGN_LSB 6
`define RDLY_LSB 3
`define NDLY_LSB 0
`define COMMIT_BIT 0
// Calibration clock division codes
`define DIV_CODE2 2'h0
`define DIV_CODE4 2'h1
`define DIV_CODE8 2'h2
`define DIV_CODE16 2'h3
// Terminal counts of the reference tick counter per division code
`define DIV_LAST2 4'h1
`define DIV_LAST4 4'h3
`define DIV_LAST8 4'h7
`define DIV_LAST16 4'hf
// Alignment reset codes
`define ALIGN_ASYNC 2'h1
`define ALIGN_SYNC 2'h2
`define ALIGN_NONE 2'h0
`define ALIGN_NONE_ALT 2'h3
// Calibration length in calibration clock periods
`define CAL_LEN_TICKS 16'h0040
`endif

// [pll_cal_pkg.sv]
`default_nettype none
package pll_cal_pkg;
  typedef struct packed {
    logic [1:0] alignMode;
    logic [2:0] refDelay;
    logic [2:0] fbDelay;
  } cnt_cfg_s;
  typedef struct packed {
    logic [4:0] spare;
    logic [1:0] calDiv;
    logic calNow;
  } cal_cfg_s;
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_RUN = 3'b010,
    CAL_DONE = 3'b100
  } cal_state_e;
endpackage
`default_nettype wire

// [cal_clk_divider.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pll_cal_defs.svh"
module cal_clk_divider (
  // Clock and reset
  input wire logic mclk,
  input wire logic sysRst,
  input wire logic clkEn,
  // Reference and selection
  input wire logic refTick,
  input wire logic [1:0] divSel,
  // Divided tick
  output logic calTick
);
  logic [3:0] cnt_reg, cnt_next;
  logic calTick_next;
  logic [3:0] lastCount;
  // Terminal count per division code
  always_comb begin
    unique case (divSel)
      `DIV_CODE2: lastCount = `DIV_LAST2;
      `DIV_CODE4: lastCount = `DIV_LAST4;
      `DIV_CODE8: lastCount = `DIV_LAST8;
      `DIV_CODE16: lastCount = `DIV_LAST16;
    endcase
    cnt_next = cnt_reg;
    calTick_next = 1'b0;
    if (refTick) begin
      if (cnt_reg >= lastCount) begin
        cnt_next = 4'h0;
        calTick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 4'h1;
      end
    end
  end
  // Counter registers
  always_ff @(posedge mclk or posedge sysRst) begin
    if (sysRst) begin
      cnt_reg <= 4'h0;
      calTick <= 1'b0;
    end else if (clkEn) begin
      cnt_reg <= cnt_next;
      calTick <= calTick_next;
    end
  end
endmodule
`default_nettype wire

// [cal_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pll_cal_defs.svh"
module cal_sequencer (
  // Clock and reset
  input wire logic mclk,
  input wire logic sysRst,
  input wire logic clkEn,
  // Control
  input wire logic calNowActive,
  input wire logic calTick,
  // Status
  output logic calBusy,
  output logic calValid
);
  import pll_cal_pkg::*;
  cal_state_e state_reg, state_next;
  logic prevNow_reg, prevNow_next;
  logic [15:0] ticks_reg, ticks_next;
  logic startCal;
  // Rising edge of the committed calibrate-now bit only
  assign startCal = calNowActive && !prevNow_reg;
  // Next state of the calibration run
  always_comb begin
    state_next = state_reg;
    ticks_next = ticks_reg;
    prevNow_next = calNowActive;
    unique case (state_reg)
      CAL_IDLE: begin
        if (startCal) begin
          state_next = CAL_RUN;
          ticks_next = 16'h0000;
        end
      end
      CAL_RUN: begin
        if (!calNowActive) begin
          state_next = CAL_IDLE;
        end else if (calTick) begin
          ticks_next = ticks_reg + 16'h0001;
          if (ticks_reg == `CAL_LEN_TICKS - 16'h0001) begin
            state_next = CAL_DONE;
          end
        end
      end
      CAL_DONE: begin
        if (!calNowActive) begin
          state_next = CAL_IDLE;
        end
      end
      default: state_next = CAL_IDLE;
    endcase
  end
  // State registers
  always_ff @(posedge mclk or posedge sysRst) begin
    if (sysRst) begin
      state_reg <= CAL_IDLE;
      ticks_reg <= 16'h0000;
      prevNow_reg <= 1'b0;
      calBusy <= 1'b0;
      calValid <= 1'b0;
    end else if (clkEn) begin
      state_reg <= state_next;
      ticks_reg <= ticks_next;
      prevNow_reg <= prevNow_next;
      calBusy <= (state_next == CAL_RUN);
      calValid <= (state_next == CAL_DONE);
    end
  end
  // Checks
  steady_no_retrig_a: assert property (@(posedge mclk) disable iff (sysRst) // RULE4
    clkEn && state_reg == CAL_DONE && calNowActive |=> state_reg == CAL_DONE)
    else $error("steady calibrate-now retriggered");
  clear_discards_a: assert property (@(posedge mclk) disable iff (sysRst) // RULE7
    clkEn && !calNowActive |=> !calValid && !calBusy)
    else $error("calibration result kept after clear");
endmodule
`default_nettype wire

// [tb_pll_cal_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_pll_cal_ctrl;
  logic mclk = 1'b0;
  logic sysRst = 1'b1;
  logic [9:0] avsAddress = 10'h000;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0000_0000;
  logic [31:0] avsReadData;
  logic avsWaitRequest, refTick = 1'b0, alignPin = 1'b0;
  logic cntAsyncReset, cntSyncReset, calClock, calBusy, calValid;
  logic [2:0] refPathDelay, fbPathDelay;
  int n_fail = 0;
  int checks = 0;
  logic [31:0] rd;

  pll_cal_ctrl DUT (
    .mclk(mclk), .sys_rst(sysRst), .clkEn(1'b1),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(4'hF),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .refTick(refTick), .alignPin(alignPin),
    .cntAsyncReset(cntAsyncReset), .cntSyncReset(cntSyncReset),
    .refPathDelay(refPathDelay), .fbPathDelay(fbPathDelay),
    .calClock(calClock), .calBusy(calBusy), .calValid(calValid)
  );

  // Clock and a reference tick every second cycle
  initial begin
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    refTick <= ~refTick;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Avalon cycle: hold request until waitrequest is sampled low
  task automatic busCycle(input logic wr, input logic [9:0] addr, input logic [31:0] data);
    int n;
    avsAddress <= addr;
    avsWriteData <= data;
    avsWrite <= wr;
    avsRead <= ~wr;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 100);
    if (n >= 100) check(1'b1, 1'b0);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    // Let an edge pass so a following request is a fresh assignment
    @(posedge mclk);
  endtask

  // Write a register and commit it
  task automatic wrCommit(input logic [9:0] addr, input logic [7:0] val);
    busCycle(1'b1, addr, {24'h00_0000, val});
    busCycle(1'b1, 10'h0C8, 32'h0000_0001);
  endtask

  // Reset values, unmapped and write-only places
  task automatic resetValues();
    busCycle(1'b0, 10'h060, 32'h0);
    check(rd, 32'h0000_0006);
    busCycle(1'b0, 10'h064, 32'h0);
    check(rd, 32'h0000_0000);
    busCycle(1'b0, 10'h0C8, 32'h0);
    check(rd, 32'h0000_0000);
    busCycle(1'b1, 10'h3F0, 32'h0000_00FF);
    busCycle(1'b0, 10'h3F0, 32'h0);
    check(rd, 32'h0000_0000);
    check({29'h0, refPathDelay}, 32'h0);
  endtask

  // Calibration with one divider code: period, start, retrigger, discard
  task automatic calRun(input logic [1:0] code);
    int n, p;
    // Holdover enables are never written, so they stay at 00
    wrCommit(10'h060, {5'h00, code, 1'b0});
    busCycle(1'b1, 10'h060, {29'h0, code, 1'b1});
    repeat (10) @(posedge mclk);
    check(calBusy, 1'b0);
    busCycle(1'b1, 10'h0C8, 32'h0000_0001);
    n = 0;
    while (calClock !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    p = 0;
    do begin
      @(posedge mclk);
      p++;
    end while (calClock !== 1'b1 && p < 200);
    check(p, 32'd4 << code);
    n = 0;
    while (calValid !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    check(calValid, 1'b1);
    busCycle(1'b0, 10'h060, 32'h0);
    check(rd, {22'h0, 2'b10, 5'h00, code, 1'b1});
    busCycle(1'b1, 10'h0C8, 32'h0000_0001);
    repeat (10) @(posedge mclk);
    check(calBusy, 1'b0);
    check(calValid, 1'b1);
    wrCommit(10'h060, {5'h00, code, 1'b0});
    repeat (3) @(posedge mclk);
    check(calValid, 1'b0);
  endtask

  // Alignment modes and path delays
  task automatic alignRun(input logic [1:0] mode);
    wrCommit(10'h064, {mode, 3'h5 - 3'(mode), 3'h2 + 3'(mode)});
    @(posedge mclk);
    check(refPathDelay, 3'h5 - 3'(mode));
    check(fbPathDelay, 3'h2 + 3'(mode));
    alignPin <= 1'b1;
    repeat (3) @(posedge mclk);
    check(cntAsyncReset, mode == 2'h1);
    check(cntSyncReset, mode == 2'h2);
    alignPin <= 1'b0;
    repeat (3) @(posedge mclk);
    check({cntAsyncReset, cntSyncReset}, 2'b00);
  endtask

  // Watchdog
  initial begin
    #(40 * 40000);
    n_fail++;
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    sysRst <= 1'b0;
    @(posedge mclk);
    resetValues();
    for (int c = 0; c < 4; c++) calRun(2'(c));
    for (int m = 0; m < 4; m++) alignRun(2'(m));
    finish_test();
  end
endmodule
`default_nettype wire
